// [logic/nand_port_params.svh]
`ifndef NAND_PORT_PARAMS_SVH
`define NAND_PORT_PARAMS_SVH

// ==========================================================
// Command codes
`define CMD_READ_STATUS 8'h70
`define CMD_SELECT_LUN_STATUS 8'h78
`define CMD_READ_MODE 8'h00
`define CMD_READ_PAGE 8'h30
`define CMD_PROGRAM_SETUP 8'h80
`define CMD_PROGRAM_CONFIRM 8'h10
`define CMD_PROGRAM_CACHE 8'h15
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_CONFIRM 8'hD0

// ==========================================================
// Status byte fields
`define STAT_READY_BIT 6
`define STAT_ARRAY_READY_BIT 5
`define STAT_UNLOCKED_BIT 7
`define STAT_FAIL_BIT 0

// ==========================================================
// Timing and reset values
`define BUSY_TIME_NS 200
`define CLK_PERIOD_NS 20
`define BUSY_CYCLES ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CACHE_ADDR_RESET 16'h0000
`define BYTE_RESET 8'h00

`endif

// [logic/nand_port_pkg.sv]
package nand_port_pkg;
   // Control pins sampled together
   typedef struct packed {
      logic cs_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
   } bus_pins_s;

   // Decoded bus cycle
   typedef enum logic [2:0] {
      CYC_NONE = 3'b000,
      CYC_CMD = 3'b001,
      CYC_ADDR = 3'b011,
      CYC_DATA = 3'b010,
      CYC_READ = 3'b110
   } cycle_e;

   // Output mode after the last command
   typedef enum logic [1:0] {
      OUT_DATA = 2'b00,
      OUT_STATUS = 2'b01
   } out_mode_e;

   // Per-LUN operation state, Gray along the usual path
   typedef enum logic [1:0] {
      LUN_IDLE = 2'b00,
      LUN_BUSY = 2'b01,
      LUN_CACHE_BUSY = 2'b11
   } lun_state_e;
endpackage

// [logic/nand_lun.sv]
`timescale 1ns/1ps
`include "nand_port_params.svh"

module nand_lun
   import nand_port_pkg::*;
#(
   parameter int BUSY_CNT = `BUSY_CYCLES,
   parameter int CACHE_DEPTH = 256
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic cache_op_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic addr_clr_in,
   input wire logic [7:0] data_in,
   output logic ready_out,
   output logic cache_busy_out,
   output logic [7:0] data_out
);
   localparam int AW = $clog2(CACHE_DEPTH);
   localparam int CW = $clog2(BUSY_CNT + 1);
   lun_state_e state_r;
   logic [CW-1:0] cnt_r;
   logic [AW-1:0] ptr_r;
   logic [7:0] mem_r [CACHE_DEPTH];
   logic [7:0] data_r;

   // ==========================================================
   // Busy timer for array operations
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= LUN_IDLE;
         cnt_r <= '0;
      end else begin
         case (state_r)
            LUN_IDLE: begin
               if (start_in) begin
                  state_r <= cache_op_in ? LUN_CACHE_BUSY : LUN_BUSY;
                  cnt_r <= CW'(BUSY_CNT);
               end
            end
            LUN_BUSY, LUN_CACHE_BUSY: begin
               if (cnt_r <= CW'(1)) begin
                  state_r <= LUN_IDLE;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r - CW'(1);
               end
            end
            default: state_r <= LUN_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Cache register pointer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ptr_r <= '0;
      end else if (addr_clr_in) begin
         ptr_r <= '0;
      end else if (wr_in || rd_in) begin
         ptr_r <= ptr_r + AW'(1);
      end
   end

   // Cache storage
   always_ff @(posedge clk_in) begin
      if (wr_in) begin
         mem_r[ptr_r] <= data_in;
      end
   end

   // Read byte register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_r <= `BYTE_RESET;
      end else if (rd_in) begin
         data_r <= mem_r[ptr_r];
      end
   end

   assign ready_out = (state_r == LUN_IDLE);
   assign cache_busy_out = (state_r == LUN_CACHE_BUSY);
   assign data_out = data_r;
endmodule

// [logic/nand_async_bus_port.sv]
`timescale 1ns/1ps
`include "nand_port_params.svh"

// What this block does
// [RULE1] Async interface active from reset; data strobe pin kept tri-stated.
// [RULE2] Chip select high disables target; all but select, lock, ready ignored.
// [RULE3] Disabled idle target enters standby; busy one waits for all LUNs.
// [RULE4] Both strobes high with select low: bus idle, nothing latched or driven; code keeps bus driven after a read until write strobe low or latch high.
// [RULE5] Write strobe rise with command latch high latches a command byte.
// [RULE6] Busy LUN ignores commands except read status and select LUN status; code also takes program cache while cache-busy.
// [RULE7] Write strobe rise with address latch high latches an address byte.
// [RULE8] Controller drives unused address bits low, issues correct cycle count.
// [RULE9] Busy LUN ignores address cycles except those after select LUN status.
// [RULE10] Write strobe rise with both latches low writes a cache byte.
// [RULE11] Unselected or busy LUNs drop data, unless busy with cached program.
// [RULE12] Ready selected LUN after read drives next byte on read strobe fall.
// [RULE13] Controller samples on rising or next falling read strobe edge.
// [RULE14] After multi-LUN work, controller selects LUN then read mode.
// [RULE15] Busy LUN ignores reads except status after status commands.
// [RULE16] Program and erase blocked while lock pin low, allowed when high.
// [RULE17] Controller should hold lock pin low until supplies are stable.
// [RULE18] Controller changes lock only when idle, then waits settle time.
// [RULE19] Lock pin honoured always, even with chip select high.
// [RULE20] Target busy when any LUN not ready; ready only when all ready.
// [RULE21] Ready pin open-drain active low: pulls low busy, released ready.
// [RULE22] Each target answers only its own chip select.
// [RULE23] Undefined strobe combinations with select low latch nothing.
module nand_async_bus_port
   import nand_port_pkg::*;
#(
   parameter int LUN_COUNT = 2,
   parameter int BUSY_CNT = `BUSY_CYCLES,
   parameter int CACHE_DEPTH = 256,
   parameter bit SECOND_TARGET = 1'b0
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic chip_select_n_in,
   input wire logic second_target_select_n_in,
   input wire logic command_latch_enable_in,
   input wire logic address_latch_strobe_in,
   input wire logic write_strobe_n_in,
   input wire logic read_strobe_n_in,
   input wire logic program_lock_n_in,
   input wire logic [7:0] io_bus_in,
   output logic [7:0] io_bus_out,
   output logic io_bus_oe_out,
   output logic data_strobe_pin_out,
   output logic data_strobe_pin_oe_out,
   output logic ready_busy_n_out,
   output logic ready_busy_n_oe_out,
   output logic standby_out,
   output logic [7:0] command_out,
   output logic [7:0] address_out,
   output logic lock_reject_out
);
   localparam int LW = (LUN_COUNT > 1) ? $clog2(LUN_COUNT) : 1;

   logic rst_s1_r, rst_n;
   bus_pins_s pins_s1_r, pins_s2_r, pins_d_r;
   logic [7:0] io_s1_r, io_s2_r;
   logic lock_s1_r, lock_s2_r;
   logic [7:0] cmd_r, addr_r;
   out_mode_e mode_r;
   logic sel_status_r;
   logic read_ok_r;
   logic [LW-1:0] lun_sel_r;
   logic [7:0] out_r;
   logic oe_r;
   logic lock_reject_r;
   logic prog_armed_r, erase_armed_r;
   logic [LUN_COUNT-1:0] lun_ready, lun_cache_busy, lun_start, lun_cache_op;
   logic [LUN_COUNT-1:0] lun_wr, lun_rd, lun_clr;
   logic [7:0] lun_data [LUN_COUNT];
   logic sel_n, we_rise, re_fall, all_ready;
   logic cmd_cyc, addr_cyc, data_cyc, read_cyc;
   logic sel_ready, sel_cache_busy;
   logic [7:0] status_byte;

   // ==========================================================
   // Reset release through two flip-flops
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pins_s1_r <= '1;
         pins_s2_r <= '1;
         pins_d_r <= '1;
         io_s1_r <= `BYTE_RESET;
         io_s2_r <= `BYTE_RESET;
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
      end else begin
         pins_s1_r <= '{cs_n: sel_n, cle: command_latch_enable_in,
                        ale: address_latch_strobe_in, we_n: write_strobe_n_in,
                        re_n: read_strobe_n_in};
         pins_s2_r <= pins_s1_r;
         pins_d_r <= pins_s2_r;
         io_s1_r <= io_bus_in;
         io_s2_r <= io_s1_r;
         lock_s1_r <= program_lock_n_in;
         lock_s2_r <= lock_s1_r;
      end
   end

   // Own chip select only
   assign sel_n = SECOND_TARGET ? second_target_select_n_in : chip_select_n_in; // RULE22

   // ==========================================================
   // Cycle decode on strobe edges
   assign we_rise = pins_s2_r.we_n && !pins_d_r.we_n;
   assign re_fall = !pins_s2_r.re_n && pins_d_r.re_n;
   // Strobe edges count only with select low
   assign cmd_cyc = we_rise && !pins_s2_r.cs_n && pins_s2_r.cle && !pins_s2_r.ale && pins_s2_r.re_n; // RULE5
   assign addr_cyc = we_rise && !pins_s2_r.cs_n && !pins_s2_r.cle && pins_s2_r.ale && pins_s2_r.re_n; // RULE7
   assign data_cyc = we_rise && !pins_s2_r.cs_n && !pins_s2_r.cle && !pins_s2_r.ale && pins_s2_r.re_n; // RULE10
   assign read_cyc = re_fall && !pins_s2_r.cs_n && !pins_s2_r.cle && !pins_s2_r.ale && pins_s2_r.we_n; // RULE12
   // Any other combination decodes to none of the above
   // RULE23 RULE4 RULE2

   // Selected LUN state
   assign sel_ready = lun_ready[lun_sel_r];
   assign sel_cache_busy = lun_cache_busy[lun_sel_r];
   assign all_ready = &lun_ready; // RULE20

   // Status byte of selected LUN
   always_comb begin
      status_byte = 8'h00;
      status_byte[`STAT_READY_BIT] = sel_ready;
      status_byte[`STAT_ARRAY_READY_BIT] = sel_ready;
      status_byte[`STAT_UNLOCKED_BIT] = lock_s2_r;
      status_byte[`STAT_FAIL_BIT] = lock_reject_r;
   end

   // ==========================================================
   // Command register
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= `BYTE_RESET;
         mode_r <= OUT_DATA;
         sel_status_r <= 1'b0;
      end else if (cmd_cyc) begin
         if (io_s2_r == `CMD_READ_STATUS) begin
            cmd_r <= io_s2_r; // RULE6
            mode_r <= OUT_STATUS;
            sel_status_r <= 1'b0;
         end else if (io_s2_r == `CMD_SELECT_LUN_STATUS) begin
            cmd_r <= io_s2_r; // RULE6
            mode_r <= OUT_STATUS;
            sel_status_r <= 1'b1;
         end else if (sel_ready || (sel_cache_busy && io_s2_r == `CMD_PROGRAM_CACHE)) begin
            cmd_r <= io_s2_r;
            mode_r <= OUT_DATA;
            sel_status_r <= 1'b0;
         end
      end else if (addr_cyc && sel_status_r) begin
         sel_status_r <= 1'b0;
      end
   end

   // ==========================================================
   // Address register and LUN select
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= `BYTE_RESET;
         lun_sel_r <= '0;
      end else if (addr_cyc) begin
         if (sel_status_r) begin
            addr_r <= io_s2_r; // RULE9
            lun_sel_r <= io_s2_r[LW-1:0];
         end else if (sel_ready) begin
            addr_r <= io_s2_r;
         end
      end
   end

   // ==========================================================
   // Program and erase arming with lock check
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prog_armed_r <= 1'b0;
         erase_armed_r <= 1'b0;
         lock_reject_r <= 1'b0;
         read_ok_r <= 1'b0;
      end else if (cmd_cyc && (sel_ready || sel_cache_busy)) begin
         prog_armed_r <= (io_s2_r == `CMD_PROGRAM_SETUP) || (prog_armed_r && io_s2_r != `CMD_READ_STATUS
                         && io_s2_r != `CMD_PROGRAM_CONFIRM && io_s2_r != `CMD_PROGRAM_CACHE);
         erase_armed_r <= (io_s2_r == `CMD_ERASE_SETUP);
         if (io_s2_r == `CMD_READ_PAGE) begin
            read_ok_r <= 1'b1;
         end else if (io_s2_r == `CMD_PROGRAM_SETUP || io_s2_r == `CMD_ERASE_SETUP) begin
            read_ok_r <= 1'b0;
         end
         if ((io_s2_r == `CMD_PROGRAM_CONFIRM || io_s2_r == `CMD_PROGRAM_CACHE) && prog_armed_r) begin
            lock_reject_r <= !lock_s2_r; // RULE16 RULE19
         end else if (io_s2_r == `CMD_ERASE_CONFIRM && erase_armed_r) begin
            lock_reject_r <= !lock_s2_r; // RULE16 RULE19
         end
      end
   end

   // ==========================================================
   // LUN strobes
   generate
      for (genvar i = 0; i < LUN_COUNT; i++) begin : g_lun
         logic hit;
         logic confirm;
         assign hit = (lun_sel_r == LW'(i));
         assign confirm = cmd_cyc && hit && lun_ready[i] && lock_s2_r && // RULE16
                          ((prog_armed_r && (io_s2_r == `CMD_PROGRAM_CONFIRM || io_s2_r == `CMD_PROGRAM_CACHE))
                           || (erase_armed_r && io_s2_r == `CMD_ERASE_CONFIRM));
         assign lun_start[i] = confirm || (cmd_cyc && hit && lun_ready[i] && io_s2_r == `CMD_READ_PAGE);
         assign lun_cache_op[i] = (io_s2_r == `CMD_PROGRAM_CACHE);
         assign lun_wr[i] = data_cyc && hit && (lun_ready[i] || lun_cache_busy[i]); // RULE11
         assign lun_rd[i] = read_cyc && hit && lun_ready[i] && mode_r == OUT_DATA && read_ok_r; // RULE12
         assign lun_clr[i] = cmd_cyc && hit && io_s2_r == `CMD_READ_MODE;
         nand_lun #(
            .BUSY_CNT(BUSY_CNT),
            .CACHE_DEPTH(CACHE_DEPTH)
         ) u_lun (
            .clk_in(clk_in),
            .rst_n_in(rst_n),
            .start_in(lun_start[i]),
            .cache_op_in(lun_cache_op[i]),
            .wr_in(lun_wr[i]),
            .rd_in(lun_rd[i]),
            .addr_clr_in(lun_clr[i] || (addr_cyc && hit && lun_ready[i])),
            .data_in(io_s2_r),
            .ready_out(lun_ready[i]),
            .cache_busy_out(lun_cache_busy[i]),
            .data_out(lun_data[i])
         );
      end
   endgenerate

   // ==========================================================
   // Data output register and enable
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_r <= `BYTE_RESET;
         oe_r <= 1'b0;
      end else if (pins_s2_r.cs_n) begin
         oe_r <= 1'b0; // RULE2
      end else if (read_cyc) begin
         if (mode_r == OUT_STATUS) begin
            out_r <= status_byte; // RULE15
            oe_r <= 1'b1;
         end else if (sel_ready && read_ok_r) begin
            oe_r <= 1'b1;
         end
      end else if (!pins_s2_r.we_n || pins_s2_r.cle || pins_s2_r.ale) begin
         oe_r <= 1'b0;
      end
   end

   // ==========================================================
   // Pin outputs
   assign io_bus_out = (mode_r == OUT_STATUS) ? out_r : lun_data[lun_sel_r];
   assign io_bus_oe_out = oe_r;
   assign data_strobe_pin_out = 1'b0;
   assign data_strobe_pin_oe_out = 1'b0; // RULE1
   assign ready_busy_n_out = 1'b0;
   assign ready_busy_n_oe_out = !all_ready; // RULE21
   assign standby_out = pins_s2_r.cs_n && all_ready; // RULE3
   assign command_out = cmd_r;
   assign address_out = addr_r;
   assign lock_reject_out = lock_reject_r;
endmodule

// [tb/nand_port_monitor.sv]
`timescale 1ns/1ps
module nand_port_monitor (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic chip_select_n_in,
   input wire logic command_latch_enable_in,
   input wire logic address_latch_strobe_in,
   input wire logic write_strobe_n_in,
   input wire logic read_strobe_n_in,
   input wire logic program_lock_n_in,
   input wire logic [7:0] io_bus_in,
   input wire logic io_bus_oe_out,
   input wire logic data_strobe_pin_oe_out,
   input wire logic ready_busy_n_out,
   input wire logic ready_busy_n_oe_out,
   input wire logic standby_out,
   input wire logic [7:0] command_out,
   input wire logic [7:0] address_out,
   input wire logic lock_reject_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // ==========================================
   // Write strobe edges by pin setting
   sequence s_wr(c, a);
      $rose(write_strobe_n_in) && !chip_select_n_in && read_strobe_n_in && c && a;
   endsequence
   sequence s_rd;
      $fell(read_strobe_n_in) && !chip_select_n_in && write_strobe_n_in
         && !command_latch_enable_in && !address_latch_strobe_in;
   endsequence
   property p_dqs; !data_strobe_pin_oe_out; endproperty
   a_dqs: assert property (p_dqs) else $error("data strobe driven");
   property p_cmd;
      s_wr(command_latch_enable_in, !address_latch_strobe_in) ##0 !ready_busy_n_oe_out
         |-> ##[3:5] command_out == io_bus_in;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command not latched");
   property p_addr;
      s_wr(!command_latch_enable_in, address_latch_strobe_in) ##0 !ready_busy_n_oe_out
         |-> ##[3:5] address_out == io_bus_in;
   endproperty
   a_addr: assert property (p_addr) else $error("address not latched");
   property p_undef;
      s_wr(command_latch_enable_in, address_latch_strobe_in)
         |-> ##1 ($stable(command_out) && $stable(address_out))[*6];
   endproperty
   a_undef: assert property (p_undef) else $error("undefined cycle latched");
   property p_desel; chip_select_n_in[*6] |-> $stable(command_out) && !io_bus_oe_out; endproperty
   a_desel: assert property (p_desel) else $error("deselected target active");
   property p_idle;
      (!chip_select_n_in && write_strobe_n_in && read_strobe_n_in)[*6]
         |-> $stable(command_out) && $stable(address_out);
   endproperty
   a_idle: assert property (p_idle) else $error("idle bus latched");
   property p_read; s_rd ##0 !ready_busy_n_oe_out |-> ##[3:5] io_bus_oe_out; endproperty
   a_read: assert property (p_read) else $error("read not driven");
   property p_stby_busy; ready_busy_n_oe_out |-> !standby_out; endproperty
   a_stby_busy: assert property (p_stby_busy) else $error("standby while busy");
   property p_stby;
      (chip_select_n_in && !ready_busy_n_oe_out)[*5] |-> standby_out;
   endproperty
   a_stby: assert property (p_stby) else $error("no standby");
   property p_rb; ready_busy_n_oe_out |-> ready_busy_n_out == 1'b0; endproperty
   a_rb: assert property (p_rb) else $error("ready pin not pulled low");
   property p_lock; $rose(lock_reject_out) |-> !program_lock_n_in; endproperty
   a_lock: assert property (p_lock) else $error("refused while unlocked");
endmodule

bind nand_async_bus_port nand_port_monitor mon (
   .clk_in(clk_in),
   .resetn_in(resetn_in),
   .chip_select_n_in(chip_select_n_in),
   .command_latch_enable_in(command_latch_enable_in),
   .address_latch_strobe_in(address_latch_strobe_in),
   .write_strobe_n_in(write_strobe_n_in),
   .read_strobe_n_in(read_strobe_n_in),
   .program_lock_n_in(program_lock_n_in),
   .io_bus_in(io_bus_in),
   .io_bus_oe_out(io_bus_oe_out),
   .data_strobe_pin_oe_out(data_strobe_pin_oe_out),
   .ready_busy_n_out(ready_busy_n_out),
   .ready_busy_n_oe_out(ready_busy_n_oe_out),
   .standby_out(standby_out),
   .command_out(command_out),
   .address_out(address_out),
   .lock_reject_out(lock_reject_out)
);

// [tb/nand_host_model.sv]
`timescale 1ns/1ps
module nand_host_model (
   input wire logic clk_in,
   input wire logic [7:0] io_in,
   output logic cs_n_out,
   output logic cs2_n_out,
   output logic cle_out,
   output logic ale_out,
   output logic we_n_out,
   output logic re_n_out,
   output logic lock_n_out,
   output logic [7:0] io_out,
   output logic io_oe_out
);
   // ==========================================
   // Pin levels at power-on
   initial begin
      cs_n_out = 1'b1;
      cs2_n_out = 1'b1;
      cle_out = 1'b0;
      ale_out = 1'b0;
      we_n_out = 1'b1;
      re_n_out = 1'b1;
      lock_n_out = 1'b0;
      io_out = 8'h00;
      io_oe_out = 1'b0;
   end
   task automatic sel(input logic v);
      @(posedge clk_in);
      cs_n_out <= v;
      repeat (6) @(posedge clk_in);
   endtask
   // Other target's select, for a target wired to the first select
   task automatic sel2(input logic v);
      @(posedge clk_in);
      cs2_n_out <= v;
      repeat (6) @(posedge clk_in);
   endtask
   // Lock moves only between sequences, then settles
   task automatic lock(input logic v);
      @(posedge clk_in);
      lock_n_out <= v;
      repeat (10) @(posedge clk_in);
   endtask
   // Write cycle: unused address bits are passed low by callers
   task automatic wr(input logic c, input logic a, input logic [7:0] d);
      @(posedge clk_in);
      cle_out <= c;
      ale_out <= a;
      io_out <= d;
      io_oe_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      we_n_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      we_n_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      cle_out <= 1'b0;
      ale_out <= 1'b0;
   endtask
   // Read cycle, slow enough to sample before the rise
   task automatic rd(output logic [7:0] d);
      @(posedge clk_in);
      io_oe_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      re_n_out <= 1'b0;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      d = io_in;
      @(posedge clk_in);
      re_n_out <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask
endmodule

// [tb/test_nand_async_bus_port.sv]
`timescale 1ns/1ps
module test_nand_async_bus_port;
   import nand_port_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cs_n, cs2_n, cle, ale, we_n, re_n, lock_n, h_oe, io_oe, dqs, dqs_oe, rb, rb_oe, stby, rej;
   logic [7:0] h_io, io_out, cmd, adr, d;
   wire logic [7:0] io_w = io_oe ? io_out : (h_oe ? h_io : ~h_io);
   wire logic rb_w = rb_oe ? rb : 1'b1;
   int n_errors = 0;
   int total_checks = 0;
   initial forever #10 clk_in = ~clk_in;
   // Busy time long enough to outlast the ignored-command and status-read steps
   nand_async_bus_port #(.BUSY_CNT(60)) dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .chip_select_n_in(cs_n),
      .second_target_select_n_in(cs2_n), .command_latch_enable_in(cle),
      .address_latch_strobe_in(ale), .write_strobe_n_in(we_n), .read_strobe_n_in(re_n),
      .program_lock_n_in(lock_n), .io_bus_in(io_w), .io_bus_out(io_out), .io_bus_oe_out(io_oe),
      .data_strobe_pin_out(dqs), .data_strobe_pin_oe_out(dqs_oe), .ready_busy_n_out(rb),
      .ready_busy_n_oe_out(rb_oe), .standby_out(stby), .command_out(cmd), .address_out(adr),
      .lock_reject_out(rej));
   nand_host_model host (
      .clk_in(clk_in), .io_in(io_w), .cs_n_out(cs_n), .cs2_n_out(cs2_n), .cle_out(cle),
      .ale_out(ale), .we_n_out(we_n), .re_n_out(re_n), .lock_n_out(lock_n), .io_out(h_io),
      .io_oe_out(h_oe));
   // ==========================================
   // Compare and closing tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic addr5;
      repeat (5) host.wr(1'b0, 1'b1, 8'h00);
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      while (rb_w !== 1'b1 && n < 100) begin
         @(posedge clk_in);
         n++;
      end
      chk(rb_w, 1'b1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      chk({dqs_oe, io_oe, rb_w, stby, cmd}, {4'b0011, 8'h00});
   endtask
   task automatic t_latch;
      host.sel(1'b0);
      host.wr(1'b1, 1'b0, 8'h70);
      chk(cmd, 8'h70);
      host.wr(1'b0, 1'b1, 8'h05);
      chk(adr, 8'h05);
      host.wr(1'b1, 1'b1, 8'h33);
      chk({cmd, adr}, 16'h7005);
      host.rd(d);
      chk({io_oe, d[6], d[7]}, 3'b110);
      host.sel(1'b1);
      host.wr(1'b1, 1'b0, 8'h60);
      chk(cmd, 8'h70);
      host.sel2(1'b0);
      host.wr(1'b1, 1'b0, 8'h60);
      chk({cmd, io_oe}, {8'h70, 1'b0});
      host.sel2(1'b1);
   endtask
   task automatic t_lock;
      host.sel(1'b0);
      host.wr(1'b1, 1'b0, 8'h80);
      addr5();
      host.wr(1'b0, 1'b0, 8'hA5);
      host.wr(1'b1, 1'b0, 8'h10);
      chk({rej, rb_w}, 2'b11);
      host.sel(1'b1);
      host.lock(1'b1);
      host.sel(1'b0);
      host.wr(1'b1, 1'b0, 8'h80);
      addr5();
      host.wr(1'b0, 1'b0, 8'h5A);
      host.wr(1'b1, 1'b0, 8'h10);
      chk({rej, rb_w}, 2'b00);
      wait_ready();
      host.wr(1'b1, 1'b0, 8'h70);
      host.rd(d);
      chk({d[7], d[6], d[0]}, 3'b110);
   endtask
   task automatic t_busy;
      host.wr(1'b1, 1'b0, 8'h00);
      addr5();
      host.wr(1'b1, 1'b0, 8'h30);
      chk(rb_w, 1'b0);
      host.wr(1'b1, 1'b0, 8'h60);
      chk(cmd, 8'h30);
      host.wr(1'b1, 1'b0, 8'h70);
      chk(cmd, 8'h70);
      host.rd(d);
      chk({io_oe, d[6]}, 2'b10);
      host.sel(1'b1);
      chk(stby, 1'b0);
      wait_ready();
      repeat (4) @(posedge clk_in);
      chk(stby, 1'b1);
      host.sel(1'b0);
      host.wr(1'b1, 1'b0, 8'h78);
      host.wr(1'b0, 1'b1, 8'h00);
      host.wr(1'b1, 1'b0, 8'h00);
      host.rd(d);
      chk(io_oe, 1'b1);
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      t_reset();
      t_latch();
      t_lock();
      t_busy();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      results();
   end
endmodule
